//--- hdl/rfir_defines.svh
`ifndef RFIR_DEFINES_SVH
`define RFIR_DEFINES_SVH

// register offsets on the internal register port
`define RFIR_OFS_SCALE_STATUS 8'h0e
`define RFIR_OFS_SCALE_MASK   8'h0f
`define RFIR_OFS_SCALE_SENSE  8'h10
`define RFIR_OFS_LIN_STATUS   8'h18
`define RFIR_OFS_LIN_MASK     8'h19
`define RFIR_OFS_LIN_SENSE    8'h1a

// field positions
`define RFIR_BIT_BUCK_A 0
`define RFIR_BIT_BUCK_B 1
`define RFIR_BIT_LIN_A  0
`define RFIR_BIT_LIN_B  1
`define RFIR_BIT_LIN_C  2

// field widths
`define RFIR_N_BUCK 2
`define RFIR_N_LIN  3

// reset values
`define RFIR_RST_SCALE_MASK   2'h3
`define RFIR_RST_LIN_MASK     3'h7
`define RFIR_RST_SCALE_STATUS 2'h0
`define RFIR_RST_LIN_STATUS   3'h0

`endif

//--- hdl/rfir_pkg.sv
package rfir_pkg;

    // one access on the internal register port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rfir_reg_req_t;

    // one read answer
    typedef struct packed {
        logic [7:0] rdata;
        logic       rvalid;
    } rfir_reg_rsp_t;

    // live regulator conditions from the analog side
    typedef struct packed {
        logic [1:0] buck_scaling_active;
        logic [2:0] lin_fault_live;
    } rfir_live_t;

endpackage

//--- hdl/rfir_sync.sv
module rfir_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage is read only by the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

//--- hdl/rfir_flag_bank.sv
module rfir_flag_bank #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // per-bit set and clear
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flag
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            // set beats clear so an event in the clearing cycle survives
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag[i] <= 1'b0;
                end else if (set[i]) begin
                    flag[i] <= 1'b1;
                end else if (clr[i]) begin
                    flag[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

//--- hdl/rfir_top.sv
// What this block does
// - A status bit whose mask is 0 pulls the interrupt output low when it is set.
// - The scaling mask register holds buck A mask in bit 0 and buck B in bit 1, both RW, reset 1.
// - The scaling sense register is read-only and shows each buck's live scaling activity.
// - The linear status register latches a current-limit event per regulator in bits 0 to 2.
// - A latched status bit clears when read or when 1 is written to it, and 0 leaves it.
// - The linear mask register holds RW mask bits 0 to 2, reset 1 so faults start masked.
// - The linear sense register is read-only and shows each regulator's live fault.
// - A mask bit of 1 keeps the interrupt output released though its status bit is set.
// - The scaling status register sets a buck's bit each time that buck finishes a change.
`include "rfir_defines.svh"

module rfir_top (
    // clock and reset
    input  wire logic                   REF_CLK,
    input  wire logic                   RST_B,
    // register port from the serial engine
    input  wire rfir_pkg::rfir_reg_req_t REG_REQ,
    output rfir_pkg::rfir_reg_rsp_t      REG_RSP,
    // live regulator conditions
    input  wire rfir_pkg::rfir_live_t    LIVE,
    // open-drain interrupt pin
    output logic                        IRQ_OUT_N,
    output logic                        IRQ_OUT_N_OE
);
    import rfir_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release

    logic [1:0] rst_pipe;
    logic       rst_n;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe[1];

    ////////////////////////////////////////////////////////////////////////////////
    // live inputs come from analog, so synchronise first

    logic [`RFIR_N_BUCK-1:0] scaling_active;
    logic [`RFIR_N_LIN-1:0]  fault_live;

    rfir_sync #(
        .W (`RFIR_N_BUCK)
    ) u_sync_buck (
        .clk   (REF_CLK),
        .rst_n (rst_n),
        .d     (LIVE.buck_scaling_active),
        .q     (scaling_active)
    );

    rfir_sync #(
        .W (`RFIR_N_LIN)
    ) u_sync_lin (
        .clk   (REF_CLK),
        .rst_n (rst_n),
        .d     (LIVE.lin_fault_live),
        .q     (fault_live)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // edge detection on synchronised levels

    logic [`RFIR_N_BUCK-1:0] scaling_active_d;
    logic [`RFIR_N_LIN-1:0]  fault_live_d;
    logic [`RFIR_N_BUCK-1:0] scale_done_evt;
    logic [`RFIR_N_LIN-1:0]  fault_evt;

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            scaling_active_d <= '0;
        end else begin
            scaling_active_d <= scaling_active;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fault_live_d <= '0;
        end else begin
            fault_live_d <= fault_live;
        end
    end

    // end of a scaling ramp, whatever started it
    assign scale_done_evt = scaling_active_d & ~scaling_active;
    // a new fault, not its continuing presence, so a read clear holds
    assign fault_evt      = fault_live & ~fault_live_d;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    logic hit_scale_status;
    logic hit_scale_mask;
    logic hit_scale_sense;
    logic hit_lin_status;
    logic hit_lin_mask;
    logic hit_lin_sense;

    assign hit_scale_status = (REG_REQ.addr == `RFIR_OFS_SCALE_STATUS);
    assign hit_scale_mask   = (REG_REQ.addr == `RFIR_OFS_SCALE_MASK);
    assign hit_scale_sense  = (REG_REQ.addr == `RFIR_OFS_SCALE_SENSE);
    assign hit_lin_status   = (REG_REQ.addr == `RFIR_OFS_LIN_STATUS);
    assign hit_lin_mask     = (REG_REQ.addr == `RFIR_OFS_LIN_MASK);
    assign hit_lin_sense    = (REG_REQ.addr == `RFIR_OFS_LIN_SENSE);

    ////////////////////////////////////////////////////////////////////////////////
    // mask registers

    logic [`RFIR_N_BUCK-1:0] scale_mask;
    logic [`RFIR_N_LIN-1:0]  lin_mask;

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            scale_mask <= `RFIR_RST_SCALE_MASK;
        end else if (REG_REQ.wr && hit_scale_mask) begin
            scale_mask <= REG_REQ.wdata[`RFIR_N_BUCK-1:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            lin_mask <= `RFIR_RST_LIN_MASK;
        end else if (REG_REQ.wr && hit_lin_mask) begin
            lin_mask <= REG_REQ.wdata[`RFIR_N_LIN-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // latched status

    logic [`RFIR_N_BUCK-1:0] scale_flag;
    logic [`RFIR_N_LIN-1:0]  lin_flag;
    logic [`RFIR_N_BUCK-1:0] scale_clr;
    logic [`RFIR_N_LIN-1:0]  lin_clr;

    // a read clears exactly the bits it returns; write-1 clears, write-0 keeps
    always_comb begin
        scale_clr = '0;
        lin_clr   = '0;
        if (REG_REQ.rd && hit_scale_status) begin
            scale_clr = scale_clr | scale_flag;
        end
        if (REG_REQ.wr && hit_scale_status) begin
            scale_clr = scale_clr | REG_REQ.wdata[`RFIR_N_BUCK-1:0];
        end
        if (REG_REQ.rd && hit_lin_status) begin
            lin_clr = lin_clr | lin_flag;
        end
        if (REG_REQ.wr && hit_lin_status) begin
            lin_clr = lin_clr | REG_REQ.wdata[`RFIR_N_LIN-1:0];
        end
    end

    rfir_flag_bank #(
        .W (`RFIR_N_BUCK)
    ) u_scale_flags (
        .clk   (REF_CLK),
        .rst_n (rst_n),
        .set   (scale_done_evt),
        .clr   (scale_clr),
        .flag  (scale_flag)
    );

    rfir_flag_bank #(
        .W (`RFIR_N_LIN)
    ) u_lin_flags (
        .clk   (REF_CLK),
        .rst_n (rst_n),
        .set   (fault_evt),
        .clr   (lin_clr),
        .flag  (lin_flag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read data, registered; unmapped offsets read 0

    logic [7:0] next_rdata;
    logic [7:0] rdata;
    logic       rvalid;

    always_comb begin
        next_rdata = 8'h00;
        if (hit_scale_status) begin
            next_rdata[`RFIR_N_BUCK-1:0] = scale_flag;
        end else if (hit_scale_mask) begin
            next_rdata[`RFIR_N_BUCK-1:0] = scale_mask;
        end else if (hit_scale_sense) begin
            next_rdata[`RFIR_N_BUCK-1:0] = scaling_active;
        end else if (hit_lin_status) begin
            next_rdata[`RFIR_N_LIN-1:0] = lin_flag;
        end else if (hit_lin_mask) begin
            next_rdata[`RFIR_N_LIN-1:0] = lin_mask;
        end else if (hit_lin_sense) begin
            next_rdata[`RFIR_N_LIN-1:0] = fault_live;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (REG_REQ.rd) begin
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= REG_REQ.rd;
        end
    end

    // one driver for the whole answer struct
    assign REG_RSP = '{rdata: rdata, rvalid: rvalid};

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt pin; registered so it never glitches on the open-drain line

    logic next_irq_drive;
    logic irq_drive;

    assign next_irq_drive = |(scale_flag & ~scale_mask)
                          | |(lin_flag & ~lin_mask);

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_drive <= 1'b0;
        end else begin
            irq_drive <= next_irq_drive;
        end
    end

    assign IRQ_OUT_N    = ~irq_drive;
    assign IRQ_OUT_N_OE = irq_drive;

endmodule

//--- tb/rfir_host_model.sv
module rfir_host_model (
    // open-drain pin seen by the host
    input  wire logic oe,
    output logic      irq_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // board pull-up holds the line high when released
    assign irq_line = oe ? 1'b0 : 1'b1;
endmodule

//--- tb/rfir_assertions.sv
module rfir_assertions (
    // clock and reset
    input wire logic                    REF_CLK,
    input wire logic                    RST_B,
    // register port
    input wire rfir_pkg::rfir_reg_req_t REG_REQ,
    input wire rfir_pkg::rfir_reg_rsp_t REG_RSP,
    // live conditions and pin
    input wire rfir_pkg::rfir_live_t    LIVE,
    input wire logic                    IRQ_OUT_N,
    input wire logic                    IRQ_OUT_N_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    import rfir_pkg::*;
    logic       armed;
    logic [7:0] rd_addr_q;
    logic [1:0] scale_mask_m;
    logic [2:0] lin_mask_m;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////////////////////////////
    // conservative: any mask write with a 0 arms the pin for good
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B)
            armed <= 1'b0;
        else if (REG_REQ.wr && ((REG_REQ.addr == 8'h0f && REG_REQ.wdata[1:0] != 2'h3)
                 || (REG_REQ.addr == 8'h19 && REG_REQ.wdata[2:0] != 3'h7)))
            armed <= 1'b1;
    end
    // port-side mirrors of the masks and of the last read offset
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_addr_q    <= 8'h00;
            scale_mask_m <= 2'h3;
            lin_mask_m   <= 3'h7;
        end else begin
            if (REG_REQ.rd) begin
                rd_addr_q <= REG_REQ.addr;
            end
            if (REG_REQ.wr && REG_REQ.addr == 8'h0f) begin
                scale_mask_m <= REG_REQ.wdata[1:0];
            end
            if (REG_REQ.wr && REG_REQ.addr == 8'h19) begin
                lin_mask_m <= REG_REQ.wdata[2:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    a_read_answer: assert property (REG_REQ.rd |=> REG_RSP.rvalid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!REG_REQ.rd |=> !REG_RSP.rvalid)
        else $error("stray read valid");
    a_pin_oe_pair: assert property (IRQ_OUT_N == !IRQ_OUT_N_OE)
        else $error("pin and enable disagree");
    a_unused_zero: assert property (REG_RSP.rvalid |-> REG_RSP.rdata[7:3] == 5'h00)
        else $error("unused bits not zero");
    a_masked_quiet: assert property (!armed |-> IRQ_OUT_N)
        else $error("masked flag drove pin");
    a_scale_sense: assert property ($stable(LIVE)[*4] ##0 REG_REQ.rd && REG_REQ.addr == 8'h10
        |=> REG_RSP.rdata[1:0] == $past(LIVE.buck_scaling_active)) else $error("scale sense");
    a_lin_sense: assert property ($stable(LIVE)[*4] ##0 REG_REQ.rd && REG_REQ.addr == 8'h1a
        |=> REG_RSP.rdata[2:0] == $past(LIVE.lin_fault_live)) else $error("fault sense");
    a_read_clears: assert property (($stable(LIVE)[*5] ##0 REG_REQ.rd && REG_REQ.addr == 8'h18)
        ##2 (REG_REQ.rd && REG_REQ.addr == 8'h18) |=> REG_RSP.rdata[2:0] == 3'h0)
        else $error("read did not clear");
    // returned flags are the ones the pin saw in that same cycle
    a_lin_unmasked_pulls: assert property (REG_RSP.rvalid && rd_addr_q == 8'h18
        && !$past(REG_REQ.wr) && |(REG_RSP.rdata[2:0] & ~lin_mask_m) |-> !IRQ_OUT_N)
        else $error("unmasked fault left pin high");
    a_scale_unmasked_pulls: assert property (REG_RSP.rvalid && rd_addr_q == 8'h0e
        && !$past(REG_REQ.wr) && |(REG_RSP.rdata[1:0] & ~scale_mask_m) |-> !IRQ_OUT_N)
        else $error("unmasked done left pin high");
    c_pin_low: cover property ($fell(IRQ_OUT_N));
    c_pin_high: cover property ($rose(IRQ_OUT_N));
    c_w1c: cover property (REG_REQ.wr && REG_REQ.addr == 8'h18);
endmodule

bind rfir_top rfir_assertions i_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .REG_REQ(REG_REQ),
    .REG_RSP(REG_RSP), .LIVE(LIVE), .IRQ_OUT_N(IRQ_OUT_N), .IRQ_OUT_N_OE(IRQ_OUT_N_OE));

//--- tb/test_regulator_fault_interrupt_regs.sv
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module test_regulator_fault_interrupt_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import rfir_pkg::*;
    logic          clk;
    logic          rst_b;
    rfir_reg_req_t req;
    rfir_reg_rsp_t rsp;
    rfir_live_t    live;
    logic          pin_n;
    logic          pin_oe;
    logic          irq_line;
    int            errors;
    int            compares;

    initial clk = 1'b0;
    always #20 clk = ~clk;

    rfir_top i_dut (.REF_CLK(clk), .RST_B(rst_b), .REG_REQ(req), .REG_RSP(rsp),
        .LIVE(live), .IRQ_OUT_N(pin_n), .IRQ_OUT_N_OE(pin_oe));
    rfir_host_model i_host (.oe(pin_oe), .irq_line(irq_line));
    ////////////////////////////////////////////////////////////////
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        `CHK(rsp.rvalid, 1'b1)
        `CHK(rsp.rdata, exp)
    endtask
    task automatic set_lin(input logic [2:0] v);
        @(posedge clk);
        live.lin_fault_live <= v;
        wait_cyc(6);
    endtask
    task automatic set_buck(input logic [1:0] v);
        @(posedge clk);
        live.buck_scaling_active <= v;
        wait_cyc(6);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        rd_reg(8'h0f, 8'h03);
        rd_reg(8'h19, 8'h07);
        rd_reg(8'h18, 8'h00);
        rd_reg(8'h0e, 8'h00);
        rd_reg(8'h05, 8'h00);
    endtask
    task automatic t_lin_fault;
        set_lin(3'h2);
        `CHK(irq_line, 1'b1)
        rd_reg(8'h1a, 8'h02);
        wr_reg(8'h19, 8'h05);
        wait_cyc(3);
        `CHK(irq_line, 1'b0)
        set_lin(3'h0);
        wr_reg(8'h18, 8'h00);
        wait_cyc(3);
        `CHK(irq_line, 1'b0)
        wr_reg(8'h18, 8'h02);
        wait_cyc(3);
        `CHK(irq_line, 1'b1)
        set_lin(3'h7);
        `CHK(irq_line, 1'b0)
        rd_reg(8'h18, 8'h07);
        rd_reg(8'h18, 8'h00);
        wait_cyc(2);
        `CHK(irq_line, 1'b1)
        wr_reg(8'h19, 8'hff);
        rd_reg(8'h19, 8'h07);
    endtask
    task automatic t_scaling;
        wr_reg(8'h0f, 8'h00);
        set_buck(2'h3);
        rd_reg(8'h10, 8'h03);
        `CHK(irq_line, 1'b1)
        set_buck(2'h2);
        `CHK(irq_line, 1'b0)
        `CHK(pin_n, 1'b0)
        rd_reg(8'h0e, 8'h01);
        set_buck(2'h0);
        rd_reg(8'h0e, 8'h02);
        wr_reg(8'h10, 8'hff);
        rd_reg(8'h10, 8'h00);
        wr_reg(8'h0f, 8'hff);
        rd_reg(8'h0f, 8'h03);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        req = '0;
        live = '0;
        rst_b = 1'b0;
        errors = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        wait_cyc(3);
        t_reset_values();
        t_lin_fault();
        t_scaling();
        report_and_stop();
    end
    // whole run is about 120 cycles, under 5 us
    initial begin
        #100us;
        errors++;
        report_and_stop();
    end
endmodule
